// File: monitor_alarm_pkg.sv
// constants shared by the monitor alarm unit
package monitor_alarm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int SRC_W  = 11;
	localparam int NDAC   = 8;
	localparam int NADC   = 4;
	localparam int NSUP   = 5;
	// register offsets
	localparam logic [7:0] OFS_GENERAL_STATUS_REGISTER   = 8'h00;
	localparam logic [7:0] OFS_ALARM_STATUS = 8'h01;
	localparam logic [7:0] OFS_TEMP_RESULT  = 8'h02;
	localparam logic [7:0] OFS_GEN_CFG0     = 8'h03;
	localparam logic [7:0] OFS_OUT_MASK     = 8'h04;
	localparam logic [7:0] OFS_DAC_PD_SRC   = 8'h05;
	localparam logic [7:0] OFS_SW_PD_SRC    = 8'h06;
	localparam logic [7:0] OFS_DAC_PD_SEL   = 8'h07;
	localparam logic [7:0] OFS_TEMP_THRESH  = 8'h08;
	localparam logic [7:0] OFS_CONV_CFG     = 8'h09;
	localparam logic [7:0] OFS_IN_HYST      = 8'h0a;
	localparam logic [7:0] OFS_SENSE_HYST   = 8'h0b;
	localparam logic [7:0] OFS_RANGE_CFG    = 8'h0c;
	localparam logic [7:0] OFS_LIMIT_BASE   = 8'h10;
	// alarm source bit positions
	localparam int SRC_TEMP   = 0;
	localparam int SRC_THERM  = 1;
	localparam int SRC_REF    = 2;
	localparam int SRC_SUPPLY = 3;
	localparam int SRC_ADC    = 7;
	// config fields
	localparam int CFG_LATCH_DIS = 0;
	localparam int CFG_PIN_POL   = 1;
	localparam int CFG_FUNC_LSB  = 8;
	localparam logic [5:0] FUNC_RESET_VAL = 6'h01;
	localparam logic [5:0] FUNC_ALARM     = 6'h02;
	// temperature codes, 128 codes per degree
	localparam logic signed [15:0] TEMP_THERMAL = 16'sh4b00;
	localparam logic [15:0] TEMP_THRESH_RST     = 16'h3e80;
	localparam logic [15:0] LIMIT_HI_RST        = 16'hffff;
	localparam logic [15:0] LIMIT_LO_RST        = 16'h0000;
	localparam logic [15:0] TEMP_LO_LIMIT       = 16'h8000;
	localparam logic [7:0]  HYST_MAX            = 8'h7f;
	// supply thresholds in millivolts (magnitudes)
	localparam logic [15:0] VCC_ON_MV      = 16'd2200;
	localparam logic [15:0] VCC_COLLAPSE   = 16'd1700;
	localparam logic [15:0] VSS_LO_ON      = 16'd2200;
	localparam logic [15:0] VSS_LO_COL     = 16'd1700;
	localparam logic [15:0] VSS_MID_ON     = 16'd3700;
	localparam logic [15:0] VSS_MID_COL    = 16'd3200;
	localparam logic [15:0] VSS_HI_ON      = 16'd6700;
	localparam logic [15:0] VSS_HI_COL     = 16'd6200;
	localparam logic [15:0] REF_ON_MV      = 16'd2000;
	localparam logic [15:0] REF_COLLAPSE   = 16'd1500;
	localparam logic [1:0]  RANGE_MID      = 2'h1;
	localparam logic [1:0]  RANGE_HIGH     = 2'h2;
endpackage : monitor_alarm_pkg

// File: limit_check.sv
// window compare with false-alarm filter and hysteresis
`timescale 1ns/1ns
`default_nettype none
module limit_check #(
	parameter int W      = 16,
	parameter bit SIGNED = 1'b0
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rstn_in,
	input  wire logic         sample_in,
	input  wire logic [W-1:0] code_in,
	input  wire logic [W-1:0] high_in,
	input  wire logic [W-1:0] low_in,
	input  wire logic [7:0]   hyst_in,
	input  wire logic [3:0]   count_in,
	output logic              alarm_out
);
	logic signed [W+1:0] code_x, hi_x, lo_x, hy_x;
	logic                above, below, out_rng, clr_hi, clr_lo;
	logic [3:0]          cnt_reg, cnt_next, need;
	logic                hi_reg, lo_reg, hi_next, lo_next;

	function automatic logic signed [W+1:0] ext(input logic [W-1:0] v);
		ext = {{2{SIGNED & v[W-1]}}, v};
	endfunction : ext

	assign code_x  = ext(code_in);
	assign hi_x    = ext(high_in);
	assign lo_x    = ext(low_in);
	assign hy_x    = (W+2)'(hyst_in > monitor_alarm_pkg::HYST_MAX ?
		monitor_alarm_pkg::HYST_MAX : hyst_in);
	assign above   = code_x > hi_x;
	assign below   = code_x < lo_x;
	assign out_rng = above | below;
	assign clr_hi  = code_x < hi_x - hy_x;
	assign clr_lo  = code_x > lo_x + hy_x;
	assign need    = (count_in == 4'h0) ? 4'h1 : count_in;
	assign alarm_out = hi_reg | lo_reg;

	always_comb begin
		cnt_next = cnt_reg;
		hi_next  = hi_reg;
		lo_next  = lo_reg;
		if (sample_in) begin
			if (hi_reg | lo_reg) begin
				cnt_next = 4'h0;
				if (hi_reg && clr_hi)
					hi_next = 1'b0;
				if (lo_reg && clr_lo)
					lo_next = 1'b0;
			end else if (!out_rng) begin
				cnt_next = 4'h0;
			end else if (cnt_reg + 4'h1 >= need) begin
				cnt_next = 4'h0;
				hi_next  = above;
				lo_next  = below;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg <= 4'h0;
			hi_reg  <= 1'b0;
			lo_reg  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			hi_reg  <= hi_next;
			lo_reg  <= lo_next;
		end
	end
endmodule : limit_check
`default_nettype wire

// File: supply_check.sv
// supply collapse detector, armed at power-on level
`timescale 1ns/1ns
`default_nettype none
module supply_check (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        sample_in,
	input  wire logic [15:0] level_mv_in,
	input  wire logic [15:0] on_mv_in,
	input  wire logic [15:0] collapse_mv_in,
	output logic             alarm_out
);
	logic [15:0] mag;
	logic        armed_reg, alarm_reg;

	assign mag = level_mv_in[15] ? 16'(-level_mv_in) : level_mv_in;
	assign alarm_out = alarm_reg;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			armed_reg <= 1'b0;
			alarm_reg <= 1'b0;
		end else if (sample_in) begin
			if (mag >= on_mv_in)
				armed_reg <= 1'b1;
			alarm_reg <= armed_reg && (mag < collapse_mv_in);
		end
	end
endmodule : supply_check
`default_nettype wire

// File: monitor_alarm_unit.sv
// monitor alarm unit: temperature result, alarms and auto power-down
`timescale 1ns/1ns
`default_nettype none
module monitor_alarm_unit (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic        temp_valid_in,
	input  wire logic [15:0] temp_code_in,
	input  wire logic [3:0]  adc_valid_in,
	input  wire logic [63:0] adc_code_in,
	input  wire logic        supply_valid_in,
	input  wire logic [79:0] supply_mv_in,
	output logic      [7:0]  dac_powerdown_out,
	output logic      [7:0]  dac_reload_out,
	output logic             switch_off_out,
	output logic             multipurpose_pin_out,
	output logic             multipurpose_pin_oe_out
);
	localparam int SW = monitor_alarm_pkg::SRC_W;

	// software-visible registers
	logic [15:0]   temp_result_reg;
	logic          latch_dis_reg, pin_pol_reg;
	logic [5:0]    pin_func_reg;
	logic [SW-1:0] out_mask_reg, dac_src_reg, sw_src_reg;
	logic [7:0]    dac_sel_reg;
	logic [15:0]   temp_thresh_reg;
	logic [11:0]   conv_cfg_reg;
	logic [7:0]    in_hyst_reg, sense_hyst_reg;
	logic [3:0]    range_reg;
	logic [15:0]   high_reg [4];
	logic [15:0]   low_reg [4];

	// alarm state
	logic [SW-1:0] status_reg, status_next;
	logic          global_reg, global_next;
	logic          pin_lat_reg, pin_lat_next;
	logic          therm_reg, therm_hold_reg, therm_hold_next;
	logic [7:0]    pd_reg, pd_next;

	// decode and condition wires
	logic          wr_gen_cfg, wr_mask, wr_dsrc, wr_ssrc, wr_dsel;
	logic          wr_thr, wr_conv, wr_ihy, wr_shy, wr_rng;
	logic          rd_gen, rd_alarm;
	logic [SW-1:0] cond, unmasked;
	logic          any_cond, any_unmasked, pin_active;
	logic          temp_alarm;
	logic [3:0]    adc_alarm;
	logic [4:0]    sup_alarm;
	logic [15:0]   on_mv [5];
	logic [15:0]   col_mv [5];
	logic [15:0]   rd_data;

	assign wr_gen_cfg = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_GEN_CFG0;
	assign wr_mask = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_OUT_MASK;
	assign wr_dsrc = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_DAC_PD_SRC;
	assign wr_ssrc = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_SW_PD_SRC;
	assign wr_dsel = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_DAC_PD_SEL;
	assign wr_thr  = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_TEMP_THRESH;
	assign wr_conv = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_CONV_CFG;
	assign wr_ihy  = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_IN_HYST;
	assign wr_shy  = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_SENSE_HYST;
	assign wr_rng  = reg_wr_in && reg_addr_in == monitor_alarm_pkg::OFS_RANGE_CFG;
	assign rd_gen  = reg_rd_in && reg_addr_in == monitor_alarm_pkg::OFS_GENERAL_STATUS_REGISTER;
	assign rd_alarm = reg_rd_in &&
		reg_addr_in == monitor_alarm_pkg::OFS_ALARM_STATUS;

	// temperature: upper threshold only, signed codes
	limit_check #(.W(16), .SIGNED(1'b1)) u_temp_check (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.sample_in  (temp_valid_in),
		.code_in    (temp_code_in),
		.high_in    (temp_thresh_reg),
		.low_in     (monitor_alarm_pkg::TEMP_LO_LIMIT),
		.hyst_in    (8'h00),
		.count_in   (conv_cfg_reg[11:8]),
		.alarm_out  (temp_alarm)
	);

	// inputs 0,1 general, 2,3 sense
	genvar gi;
	generate
		for (gi = 0; gi < monitor_alarm_pkg::NADC; gi++) begin : g_adc
			limit_check #(.W(16), .SIGNED(1'b0)) u_adc_check (
				.clk_sys_in (clk_sys_in),
				.rstn_in    (rstn_in),
				.sample_in  (adc_valid_in[gi]),
				.code_in    (adc_code_in[gi*16 +: 16]),
				.high_in    (high_reg[gi]),
				.low_in     (low_reg[gi]),
				.hyst_in    (gi < 2 ? in_hyst_reg : sense_hyst_reg),
				.count_in   (gi < 2 ? conv_cfg_reg[3:0] : conv_cfg_reg[7:4]),
				.alarm_out  (adc_alarm[gi])
			);
		end
		// supplies: 0 vcca, 1 vccb, 2 vssa, 3 vssb, 4 reference
		for (gi = 0; gi < monitor_alarm_pkg::NSUP; gi++) begin : g_sup
			logic [1:0] rng;
			assign rng = range_reg[(gi & 1)*2 +: 2];
			if (gi < 2) begin : g_vcc
				assign on_mv[gi]  = monitor_alarm_pkg::VCC_ON_MV;
				assign col_mv[gi] = monitor_alarm_pkg::VCC_COLLAPSE;
			end else if (gi < 4) begin : g_vss
				assign on_mv[gi] = (rng == monitor_alarm_pkg::RANGE_HIGH) ?
					monitor_alarm_pkg::VSS_HI_ON :
					(rng == monitor_alarm_pkg::RANGE_MID) ?
					monitor_alarm_pkg::VSS_MID_ON : monitor_alarm_pkg::VSS_LO_ON;
				assign col_mv[gi] = (rng == monitor_alarm_pkg::RANGE_HIGH) ?
					monitor_alarm_pkg::VSS_HI_COL :
					(rng == monitor_alarm_pkg::RANGE_MID) ?
					monitor_alarm_pkg::VSS_MID_COL :
					monitor_alarm_pkg::VSS_LO_COL;
			end else begin : g_ref
				assign on_mv[gi]  = monitor_alarm_pkg::REF_ON_MV;
				assign col_mv[gi] = monitor_alarm_pkg::REF_COLLAPSE;
			end
			supply_check u_sup_check (
				.clk_sys_in     (clk_sys_in),
				.rstn_in        (rstn_in),
				.sample_in      (supply_valid_in),
				.level_mv_in    (supply_mv_in[gi*16 +: 16]),
				.on_mv_in       (on_mv[gi]),
				.collapse_mv_in (col_mv[gi]),
				.alarm_out      (sup_alarm[gi])
			);
		end
	endgenerate

	// live alarm conditions by source bit
	assign cond = {adc_alarm, sup_alarm[3:0], sup_alarm[4], therm_reg,
		temp_alarm};
	assign unmasked     = cond & ~out_mask_reg;
	assign any_cond     = |cond;
	assign any_unmasked = |unmasked;

	always_comb begin
		// set wins over read-clear
		status_next = (rd_alarm ? '0 : status_reg) | cond;
		if (latch_dis_reg) begin
			global_next  = any_cond;
			pin_lat_next = 1'b0;
		end else begin
			global_next  = (global_reg & ~rd_gen) | any_cond;
			pin_lat_next = (pin_lat_reg & ~rd_gen) | any_unmasked;
		end
		// thermal power-down persists until flag cleared by read
		therm_hold_next = therm_hold_reg;
		if (therm_reg && dac_src_reg[monitor_alarm_pkg::SRC_THERM])
			therm_hold_next = 1'b1;
		else if (rd_alarm)
			therm_hold_next = 1'b0;
		pd_next = ({8{|(cond & dac_src_reg)}} & dac_sel_reg) |
			{8{therm_hold_next}};
	end

	assign pin_active = latch_dis_reg ? any_unmasked : pin_lat_reg;
	assign multipurpose_pin_oe_out = (pin_func_reg ==
		monitor_alarm_pkg::FUNC_ALARM);
	assign multipurpose_pin_out = pin_active ~^ pin_pol_reg;

	always_comb begin
		rd_data = 16'h0000;
		case (reg_addr_in)
			monitor_alarm_pkg::OFS_GENERAL_STATUS_REGISTER:   rd_data = {15'h0000, global_reg};
			monitor_alarm_pkg::OFS_ALARM_STATUS: rd_data = 16'(status_reg);
			monitor_alarm_pkg::OFS_TEMP_RESULT:  rd_data = temp_result_reg;
			monitor_alarm_pkg::OFS_GEN_CFG0:     rd_data = {2'h0, pin_func_reg,
				6'h00, pin_pol_reg, latch_dis_reg};
			monitor_alarm_pkg::OFS_OUT_MASK:     rd_data = 16'(out_mask_reg);
			monitor_alarm_pkg::OFS_DAC_PD_SRC:   rd_data = 16'(dac_src_reg);
			monitor_alarm_pkg::OFS_SW_PD_SRC:    rd_data = 16'(sw_src_reg);
			monitor_alarm_pkg::OFS_DAC_PD_SEL:   rd_data = {8'h00, dac_sel_reg};
			monitor_alarm_pkg::OFS_TEMP_THRESH:  rd_data = temp_thresh_reg;
			monitor_alarm_pkg::OFS_CONV_CFG:     rd_data = {4'h0, conv_cfg_reg};
			monitor_alarm_pkg::OFS_IN_HYST:      rd_data = {8'h00, in_hyst_reg};
			monitor_alarm_pkg::OFS_SENSE_HYST:   rd_data = {8'h00, sense_hyst_reg};
			monitor_alarm_pkg::OFS_RANGE_CFG:    rd_data = {12'h000, range_reg};
			default: begin
				if (reg_addr_in[7:3] == monitor_alarm_pkg::OFS_LIMIT_BASE[7:3])
					rd_data = reg_addr_in[0] ? low_reg[reg_addr_in[2:1]] :
						high_reg[reg_addr_in[2:1]];
			end
		endcase
	end

	// configuration registers
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			latch_dis_reg   <= 1'b0;
			pin_pol_reg     <= 1'b0;
			pin_func_reg    <= monitor_alarm_pkg::FUNC_RESET_VAL;
			out_mask_reg    <= '0;
			dac_src_reg     <= '0;
			sw_src_reg      <= '0;
			dac_sel_reg     <= 8'h00;
			temp_thresh_reg <= monitor_alarm_pkg::TEMP_THRESH_RST;
			conv_cfg_reg    <= 12'h000;
			in_hyst_reg     <= 8'h00;
			sense_hyst_reg  <= 8'h00;
			range_reg       <= 4'h0;
		end else begin
			if (wr_gen_cfg) begin
				latch_dis_reg <= reg_wdata_in[monitor_alarm_pkg::CFG_LATCH_DIS];
				pin_pol_reg   <= reg_wdata_in[monitor_alarm_pkg::CFG_PIN_POL];
				pin_func_reg  <= reg_wdata_in[monitor_alarm_pkg::CFG_FUNC_LSB +: 6];
			end
			if (wr_mask)
				out_mask_reg <= reg_wdata_in[SW-1:0];
			if (wr_dsrc)
				dac_src_reg <= reg_wdata_in[SW-1:0];
			if (wr_ssrc)
				sw_src_reg <= reg_wdata_in[SW-1:0];
			if (wr_dsel)
				dac_sel_reg <= reg_wdata_in[7:0];
			if (wr_thr)
				temp_thresh_reg <= reg_wdata_in;
			if (wr_conv)
				conv_cfg_reg <= reg_wdata_in[11:0];
			if (wr_ihy)
				in_hyst_reg <= reg_wdata_in[7:0];
			if (wr_shy)
				sense_hyst_reg <= reg_wdata_in[7:0];
			if (wr_rng)
				range_reg <= reg_wdata_in[3:0];
		end
	end

	// limit registers, one high and one low per input
	generate
		for (gi = 0; gi < monitor_alarm_pkg::NADC; gi++) begin : g_lim
			logic hit;
			assign hit = reg_wr_in &&
				reg_addr_in[7:3] == monitor_alarm_pkg::OFS_LIMIT_BASE[7:3] &&
				reg_addr_in[2:1] == 2'(gi);
			always_ff @(posedge clk_sys_in or negedge rstn_in) begin
				if (!rstn_in) begin
					high_reg[gi] <= monitor_alarm_pkg::LIMIT_HI_RST;
					low_reg[gi]  <= monitor_alarm_pkg::LIMIT_LO_RST;
				end else if (hit && !reg_addr_in[0]) begin
					high_reg[gi] <= reg_wdata_in;
				end else if (hit) begin
					low_reg[gi] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	// temperature capture and thermal compare
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			temp_result_reg <= 16'h0000;
			therm_reg       <= 1'b0;
		end else begin
			if (temp_valid_in) begin
				temp_result_reg <= temp_code_in;
				therm_reg <= $signed(temp_code_in) >
					monitor_alarm_pkg::TEMP_THERMAL;
			end
		end
	end

	// alarm state, power-down and read data
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_reg     <= '0;
			global_reg     <= 1'b0;
			pin_lat_reg    <= 1'b0;
			therm_hold_reg <= 1'b0;
			pd_reg         <= 8'h00;
			dac_reload_out <= 8'h00;
			switch_off_out <= 1'b0;
			reg_rdata_out  <= 16'h0000;
		end else begin
			status_reg     <= status_next;
			global_reg     <= global_next;
			pin_lat_reg    <= pin_lat_next;
			therm_hold_reg <= therm_hold_next;
			pd_reg         <= pd_next;
			dac_reload_out <= pd_reg & ~pd_next;
			switch_off_out <= |(cond & sw_src_reg) | therm_hold_next;
			if (reg_rd_in)
				reg_rdata_out <= rd_data;
		end
	end

	assign dac_powerdown_out = pd_reg;
endmodule : monitor_alarm_unit
`default_nettype wire

// File: monitor_alarm_unit_assertions.sv
// port-level checker for the monitor alarm unit
`timescale 1ns/1ns
`default_nettype none
module monitor_alarm_unit_assertions (
	input wire logic        clk_sys_in,
	input wire logic        rstn_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        temp_valid_in,
	input wire logic [15:0] temp_code_in,
	input wire logic [3:0]  adc_valid_in,
	input wire logic [63:0] adc_code_in,
	input wire logic        supply_valid_in,
	input wire logic [79:0] supply_mv_in,
	input wire logic [7:0]  dac_powerdown_out,
	input wire logic [7:0]  dac_reload_out,
	input wire logic        switch_off_out,
	input wire logic        multipurpose_pin_out,
	input wire logic        multipurpose_pin_oe_out
);
	logic [15:0] cfg_reg;
	logic [15:0] temp_reg;
	logic [10:0] mask_reg;
	logic [10:0] src_reg;
	logic        pin_act;
	logic        wr_any;
	// active level of the pin under the programmed polarity
	assign pin_act = cfg_reg[1] ? multipurpose_pin_out : !multipurpose_pin_out;
	assign wr_any = reg_wr_in;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_reg <= 16'h0100;
			temp_reg <= 16'h0000;
			mask_reg <= 11'h000;
			src_reg <= 11'h000;
		end else begin
			if (reg_wr_in && reg_addr_in == 8'h03) cfg_reg <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == 8'h04) mask_reg <= reg_wdata_in[10:0];
			if (reg_wr_in && reg_addr_in == 8'h05) src_reg <= reg_wdata_in[10:0];
			if (temp_valid_in) temp_reg <= temp_code_in;
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);
	a_oe_alarm_func: assert property (
		wr_any && reg_addr_in == 8'h03 && reg_wdata_in[13:8] == 6'h02
		|=> multipurpose_pin_oe_out) else $error("pin enable missing");
	a_temp_result_echo: assert property (
		reg_rd_in && reg_addr_in == 8'h02 && !temp_valid_in
		&& !$past(temp_valid_in) |=> reg_rdata_out == temp_reg)
		else $error("temperature result differs from sample");
	a_latched_pin_hold: assert property (
		!cfg_reg[0] && pin_act && !wr_any
		&& !(reg_rd_in && reg_addr_in == 8'h00) |=> pin_act)
		else $error("latched pin released without read");
	a_masked_pin_quiet: assert property (
		mask_reg == 11'h7ff && !pin_act && !wr_any |=> !pin_act)
		else $error("pin raised by masked alarm");
	a_pd_no_source: assert property (
		src_reg == 11'h000 && dac_powerdown_out == 8'h00 && !wr_any
		|=> dac_powerdown_out == 8'h00) else $error("power-down w/o source");
	a_thermal_pd_all: assert property (
		temp_valid_in && src_reg[1]
		&& $signed(temp_code_in) > monitor_alarm_pkg::TEMP_THERMAL
		|-> ##[1:4] dac_powerdown_out == 8'hff) else $error("no thermal pd");
	a_reload_on_release: assert property (
		$fell(dac_powerdown_out[0]) |-> ##[0:1] dac_reload_out[0])
		else $error("no reload after release");
	a_reload_single: assert property (
		dac_reload_out[0] |=> !dac_reload_out[0]) else $error("long reload");
	a_reset_outputs: assert property (
		$rose(rstn_in) |-> dac_powerdown_out == 8'h00 && !switch_off_out
		&& !multipurpose_pin_oe_out) else $error("outputs not cleared");
endmodule : monitor_alarm_unit_assertions
bind monitor_alarm_unit monitor_alarm_unit_assertions
	i_monitor_alarm_unit_assertions (.*);
`default_nettype wire

// File: test_monitor_alarm_unit.sv
// self-checking bench for the monitor alarm unit
`timescale 1ns/1ns
`default_nettype none
module test_monitor_alarm_unit;
	logic        clk_sys_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic [15:0] reg_rdata_out;
	logic        temp_valid_in = 1'b0;
	logic [15:0] temp_code_in = 16'h0000;
	logic [3:0]  adc_valid_in = 4'h0;
	logic [63:0] adc_code_in = 64'h0;
	logic        supply_valid_in = 1'b0;
	logic [79:0] supply_mv_in = 80'h0;
	logic [7:0]  dac_powerdown_out;
	logic [7:0]  dac_reload_out;
	logic        switch_off_out;
	logic        multipurpose_pin_out;
	logic        multipurpose_pin_oe_out;
	logic [7:0]  last_reload = 8'h00;
	logic [15:0] v;
	logic [15:0] codes [4] = '{16'hffc9, 16'hffff, 16'h0080, 16'h0c80};
	int          checks = 0;
	int          n_mismatch = 0;
	monitor_alarm_unit i_monitor_alarm_unit (.*);
	always #10 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in)
		if (dac_reload_out != 8'h00)
			last_reload = dac_reload_out;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(negedge clk_sys_in);
		reg_addr_in = ad;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_sys_in);
		reg_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [15:0] d);
		@(negedge clk_sys_in);
		reg_addr_in = ad;
		reg_rd_in = 1'b1;
		@(negedge clk_sys_in);
		reg_rd_in = 1'b0;
		d = reg_rdata_out;
	endtask : rd
	task automatic rdc(input logic [7:0] ad, input logic [15:0] e);
		logic [15:0] g;
		rd(ad, g);
		chk(g, e);
	endtask : rdc
	task automatic tmp(input logic [15:0] c);
		@(negedge clk_sys_in);
		temp_code_in = c;
		temp_valid_in = 1'b1;
		@(negedge clk_sys_in);
		temp_valid_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
	endtask : tmp
	task automatic adc(input logic [15:0] c);
		@(negedge clk_sys_in);
		adc_code_in[15:0] = c;
		adc_valid_in = 4'h1;
		@(negedge clk_sys_in);
		adc_valid_in = 4'h0;
		repeat (4) @(negedge clk_sys_in);
	endtask : adc
	task automatic sup(input logic [79:0] s);
		@(negedge clk_sys_in);
		supply_mv_in = s;
		supply_valid_in = 1'b1;
		@(negedge clk_sys_in);
		supply_valid_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
	endtask : sup
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (8) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		rdc(8'h08, 16'h3e80);
		rdc(8'h03, 16'h0100);
		rdc(8'h01, 16'h0000);
		rdc(8'h0d, 16'h0000);
		chk({15'h0, multipurpose_pin_oe_out}, 16'h0000);
		$display("test reset done");
		foreach (codes[i]) begin
			tmp(codes[i]);
			rdc(8'h02, codes[i]);
		end
		$display("test temperature format done");
		// N=2 for general inputs, window 0x0100..0x1000, hysteresis 16
		wr(8'h09, 16'h0002);
		wr(8'h0a, 16'h0010);
		wr(8'h10, 16'h1000);
		wr(8'h11, 16'h0100);
		adc(16'h2000);
		adc(16'h0800);
		adc(16'h2000);
		rdc(8'h01, 16'h0000);
		adc(16'h2000);
		rdc(8'h01, 16'h0080);
		adc(16'h0ff8);
		rd(8'h01, v);
		rdc(8'h01, 16'h0080);
		adc(16'h0fef);
		rd(8'h01, v);
		rdc(8'h01, 16'h0000);
		$display("test converter window done");
		wr(8'h08, 16'hffe7);
		tmp(16'hffc9);
		rdc(8'h01, 16'h0000);
		tmp(16'h0000);
		rdc(8'h00, 16'h0001);
		rdc(8'h01, 16'h0001);
		tmp(16'hffc9);
		rd(8'h01, v);
		rdc(8'h01, 16'h0000);
		$display("test temperature alarm done");
		// latched flag outlives the condition; this read also frees the pin
		rdc(8'h00, 16'h0001);
		wr(8'h03, 16'h0200);
		chk({15'h0, multipurpose_pin_oe_out}, 16'h0001);
		chk({15'h0, multipurpose_pin_out}, 16'h0001);
		tmp(16'h0000);
		tmp(16'hffc9);
		chk({15'h0, multipurpose_pin_out}, 16'h0000);
		rd(8'h00, v);
		chk({15'h0, multipurpose_pin_out}, 16'h0001);
		wr(8'h03, 16'h0201);
		tmp(16'h0000);
		chk({15'h0, multipurpose_pin_out}, 16'h0000);
		tmp(16'hffc9);
		chk({15'h0, multipurpose_pin_out}, 16'h0001);
		rdc(8'h00, 16'h0000);
		wr(8'h04, 16'h07ff);
		tmp(16'h0000);
		chk({15'h0, multipurpose_pin_out}, 16'h0001);
		rdc(8'h01, 16'h0001);
		tmp(16'hffc9);
		wr(8'h04, 16'h0000);
		wr(8'h03, 16'h0200);
		rd(8'h00, v);
		rd(8'h01, v);
		$display("test alarm pin done");
		wr(8'h07, 16'h0005);
		wr(8'h05, 16'h0001);
		tmp(16'h0000);
		chk({8'h00, dac_powerdown_out}, 16'h0005);
		tmp(16'hffc9);
		chk({8'h00, dac_powerdown_out}, 16'h0000);
		chk({8'h00, last_reload}, 16'h0005);
		$display("test power-down done");
		wr(8'h05, 16'h0002);
		tmp(16'h4b00);
		chk({8'h00, dac_powerdown_out}, 16'h0000);
		tmp(16'h4b01);
		chk({8'h00, dac_powerdown_out}, 16'h00ff);
		tmp(16'hffc9);
		chk({8'h00, dac_powerdown_out}, 16'h00ff);
		rd(8'h01, v);
		repeat (4) @(negedge clk_sys_in);
		chk({8'h00, dac_powerdown_out}, 16'h0000);
		chk({8'h00, last_reload}, 16'h00ff);
		rd(8'h00, v);
		$display("test thermal hold done");
		// group B mid range; vcca drives DAC power-down, reference the switch
		wr(8'h0c, 16'h0004);
		wr(8'h05, 16'h0008);
		wr(8'h06, 16'h0004);
		sup({5{16'h03e8}});
		rdc(8'h01, 16'h0000);
		sup({16'h07d0, 16'hf18c, 16'hf768, 16'h0898, 16'h0898});
		sup({16'h05db, 16'hf381, 16'hf95d, 16'h06a4, 16'h06a3});
		sup({16'h05db, 16'hf381, 16'hf95d, 16'h06a4, 16'h06a3});
		rdc(8'h01, 16'h006c);
		chk({8'h00, dac_powerdown_out}, 16'h0005);
		chk({15'h0, switch_off_out}, 16'h0001);
		chk({15'h0, multipurpose_pin_out}, 16'h0000);
		$display("test supply alarms done");
		// reset mid-run: arming, alarms and latches all drop
		rstn_in = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		sup({16'h05db, 16'hf381, 16'hf95d, 16'h06a4, 16'h06a3});
		rdc(8'h01, 16'h0000);
		rdc(8'h00, 16'h0000);
		chk({8'h00, dac_powerdown_out}, 16'h0000);
		chk({15'h0, switch_off_out}, 16'h0000);
		chk({15'h0, multipurpose_pin_oe_out}, 16'h0000);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : test_monitor_alarm_unit
`default_nettype wire
